//--- rtl/sgc_params.svh
// constants for the switch global control bank
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH

// register indices; byte address is four times the index
`define SGC_IDX_STORM_HI 6'h06
`define SGC_IDX_STORM_LO 6'h07
`define SGC_IDX_FTEST_1 6'h08
`define SGC_IDX_FTEST_2 6'h09
`define SGC_IDX_FTEST_3 6'h0a
`define SGC_IDX_LOOP_LED 6'h0b
`define SGC_IDX_PMAP_LO 6'h0c
`define SGC_IDX_PMAP_HI 6'h0d

// reset values
`define SGC_RST_STORM_HI 3'h0
`define SGC_RST_STORM_LO 8'h63
`define SGC_RST_FTEST_1 8'h00
`define SGC_RST_FTEST_2 8'h24
`define SGC_RST_FTEST_3 8'h35
`define SGC_RST_PMAP_LO 8'h50
`define SGC_RST_PMAP_HI 8'hfa

// loopback and led control field positions
`define SGC_LL_LED_HI 7
`define SGC_LL_RSVD 6
`define SGC_LL_ERR_DROP 5
`define SGC_LL_TEST 4
`define SGC_LL_LOOP_HI 3
`define SGC_LL_LOOP_LO 2
`define SGC_LL_LED_LO 1
`define SGC_LL_DIRECT 0
`define SGC_RST_LOOP_HI 1'b1

// storm protection
`define SGC_STORM_BLK_BYTES 64
`define SGC_PERIOD_100_MS 67
`define SGC_PERIOD_10_MS 500
`define SGC_CLK_KHZ 40000
`define SGC_PORTS 3

`endif

//--- rtl/sgc_pkg.sv
// types shared by the switch global control bank
package sgc_pkg;
   typedef enum logic [1:0] {
      SGC_LOOP_P2_COPPER,
      SGC_LOOP_P2_MAC,
      SGC_LOOP_P1_OPTICAL
   } sgc_loop_pos_e;
   typedef logic [10:0] sgc_limit_t;
   typedef logic [1:0] sgc_qpri_t;
endpackage

//--- rtl/sgc_storm_if.sv
// storm limiter hookup between the bank and the per-port counters
`timescale 1ns/100ps
interface sgc_storm_if;
   import sgc_pkg::*;
   sgc_limit_t limit;
   logic [2:0] byte_stb;
   logic [2:0] speed_10;
   logic [2:0] drop;
   modport bank (output limit, byte_stb, speed_10, input drop);
   modport storm (input limit, byte_stb, speed_10, output drop);
endinterface

//--- rtl/sgc_storm.sv
// per-port broadcast storm block counters
`timescale 1ns/100ps
`include "sgc_params.svh"
module sgc_storm #(
   parameter int unsigned PERIOD_100_CYC =
      `SGC_PERIOD_100_MS * `SGC_CLK_KHZ,
   parameter int unsigned PERIOD_10_CYC =
      `SGC_PERIOD_10_MS * `SGC_CLK_KHZ
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // bank side
   sgc_storm_if.storm st
);
   import sgc_pkg::*;
   localparam int BW = $clog2(`SGC_STORM_BLK_BYTES);

   genvar p;
   generate
      for (p = 0; p < `SGC_PORTS; p++)
      begin : g_port
         logic [24:0] tmr_q, tmr_d;
         logic [BW-1:0] byte_q, byte_d;
         logic [11:0] blk_q, blk_d;
         logic drop_q, drop_d;
         logic [24:0] last;

         // a speed change mid-period still ends the period
         always_comb
         begin
            last = st.speed_10[p] ? 25'(PERIOD_10_CYC - 1)
                                  : 25'(PERIOD_100_CYC - 1);
            tmr_d = tmr_q + 25'h1;
            byte_d = byte_q;
            blk_d = blk_q;
            if (tmr_q >= last) // [RULE4]
            begin
               tmr_d = 25'h0; // [RULE6]
               byte_d = '0;
               blk_d = 12'h0;
            end
            else if (st.byte_stb[p] && !drop_q) // [RULE3]
            begin
               byte_d = byte_q + 1'b1;
               if (byte_q == BW'(`SGC_STORM_BLK_BYTES - 1))
                  blk_d = blk_q + 12'h1;
            end
            // blocks at the limit: further data in this period is dropped
            drop_d = ({1'b0, st.limit} <= blk_d); // [RULE6]
         end

         always_ff @(posedge clk_i)
         begin
            if (!rst_n_i)
            begin
               tmr_q <= 25'h0;
               byte_q <= '0;
               blk_q <= 12'h0;
               drop_q <= 1'b0;
            end
            else if (ce_i)
            begin
               tmr_q <= tmr_d;
               byte_q <= byte_d;
               blk_q <= blk_d;
               drop_q <= drop_d;
            end
         end
         assign st.drop[p] = drop_q;
      end
   endgenerate
endmodule

//--- rtl/sgc_bank.sv
// switch global control register bank with apb slave and its consumers
`timescale 1ns/100ps
`include "sgc_params.svh"

// Summary of operation
// [RULE1] low storm limit byte is held at 0x07, joined with upper bits
// [RULE2] limit bits 10:8 come from bits 2:0 of register 0x06
// [RULE3] ingress data counted per port in 64-byte blocks, capped at limit
// [RULE4] measurement period is 67 ms at 100 Mbit/s, 500 ms at 10 Mbit/s
// [RULE5] low storm limit byte resets to 0x63
// [RULE6] block counters clear every period; excess data is dropped
// [RULE7] factory test registers reset to 0x00, 0x24, 0x35; software keeps them
// [RULE8] loopback with error drop set discards oam and errored frames
// [RULE9] loopback with error drop clear discards only oam frames
// [RULE10] loop bits 00 copper, 10 mac, x1 optical; high ignored if low set
// [RULE11] software keeps testing-mode bit 4 at zero
// [RULE12] led mode is bit 7 high, bit 1 low of loopback/led register
// [RULE13] led, error drop and low loop bits load from straps at reset
// [RULE14] bit 0 enables direct-mode forwarding from port 3
// [RULE15] tag priority value indexes two-bit queue fields in 0x0c/0x0d
// [RULE16] reset map: 0,1 to 00; 2,3 to 01; 4,5 to 10; 6,7 to 11
module sgc_bank #(
   parameter int unsigned PERIOD_100_CYC =
      `SGC_PERIOD_100_MS * `SGC_CLK_KHZ,
   parameter int unsigned PERIOD_10_CYC =
      `SGC_PERIOD_10_MS * `SGC_CLK_KHZ
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // strap levels sampled during reset
   input wire logic led_mode_sel_hi_i,
   input wire logic led_mode_sel_lo_i,
   input wire logic error_drop_strap_i,
   input wire logic loop_position_strap_i,
   // storm protection per port
   input wire logic [2:0] storm_byte_i,
   input wire logic [2:0] port_speed_10_i,
   output logic [2:0] storm_drop_o,
   // loopback frame verdict
   input wire logic loop_mode_i,
   input wire logic loop_frame_done_i,
   input wire logic loop_frame_oam_i,
   input wire logic loop_frame_err_i,
   output logic loop_forward_o,
   output logic loop_discard_o,
   // static controls
   output sgc_pkg::sgc_loop_pos_e loop_pos_o,
   output logic [1:0] led_mode_o,
   output logic direct_fwd_en_o,
   // 802.1p priority lookup
   input wire logic tag_valid_i,
   input wire logic [2:0] tag_pri_i,
   output sgc_pkg::sgc_qpri_t queue_pri_o,
   output logic queue_pri_valid_o
);
   import sgc_pkg::*;

   // register file
   logic [2:0] storm_hi_q, storm_hi_d;
   logic [7:0] storm_lo_q, storm_lo_d;
   logic [7:0] ftest1_q, ftest1_d;
   logic [7:0] ftest2_q, ftest2_d;
   logic [7:0] ftest3_q, ftest3_d;
   logic [7:0] loop_led_q, loop_led_d;
   logic [7:0] pmap_lo_q, pmap_lo_d;
   logic [7:0] pmap_hi_q, pmap_hi_d;

   // apb slave state
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;

   logic [5:0] idx;
   logic aligned;
   logic hit;
   logic setup;
   logic wr_en;
   logic [7:0] rd_byte;
   logic [7:0] wbyte;

   assign idx = paddr_i[7:2];
   assign aligned = (paddr_i[1:0] == 2'b00);
   assign setup = psel_i && !penable_i;
   assign wbyte = pwdata_i[7:0];

   // decode and read mux
   always_comb
   begin
      hit = aligned;
      rd_byte = 8'h00;
      unique case (idx)
         `SGC_IDX_STORM_HI: rd_byte = {5'h00, storm_hi_q};
         `SGC_IDX_STORM_LO: rd_byte = storm_lo_q;
         `SGC_IDX_FTEST_1: rd_byte = ftest1_q;
         `SGC_IDX_FTEST_2: rd_byte = ftest2_q;
         `SGC_IDX_FTEST_3: rd_byte = ftest3_q;
         `SGC_IDX_LOOP_LED: rd_byte = loop_led_q;
         `SGC_IDX_PMAP_LO: rd_byte = pmap_lo_q;
         `SGC_IDX_PMAP_HI: rd_byte = pmap_hi_q;
         default: hit = 1'b0;
      endcase
   end

   // a write commits only at the access edge that also sees pready high
   assign wr_en = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q;

   // no wait state: answer is prepared during setup, shown in the first access cycle
   always_comb
   begin
      pready_d = setup;
      pslverr_d = setup && !hit;
      prdata_d = prdata_q;
      if (setup)
         prdata_d = (hit && !pwrite_i) ? {24'h0, rd_byte} : 32'h0;
      else if (psel_i && penable_i && pready_q)
         prdata_d = 32'h0;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else if (ce_i)
      begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;

   // register writes
   always_comb
   begin
      storm_hi_d = storm_hi_q;
      storm_lo_d = storm_lo_q;
      ftest1_d = ftest1_q;
      ftest2_d = ftest2_q;
      ftest3_d = ftest3_q;
      loop_led_d = loop_led_q;
      pmap_lo_d = pmap_lo_q;
      pmap_hi_d = pmap_hi_q;
      if (wr_en)
      begin
         unique case (idx)
            `SGC_IDX_STORM_HI: storm_hi_d = wbyte[2:0]; // [RULE2]
            `SGC_IDX_STORM_LO: storm_lo_d = wbyte; // [RULE1]
            // stored as written; normal firmware leaves the defaults
            `SGC_IDX_FTEST_1: ftest1_d = wbyte; // [RULE7]
            `SGC_IDX_FTEST_2: ftest2_d = wbyte; // [RULE7]
            `SGC_IDX_FTEST_3: ftest3_d = wbyte; // [RULE7]
            // the testing-mode bit is kept but drives nothing here
            `SGC_IDX_LOOP_LED: loop_led_d = wbyte; // [RULE11]
            `SGC_IDX_PMAP_LO: pmap_lo_d = wbyte;
            `SGC_IDX_PMAP_HI: pmap_hi_d = wbyte;
            default: ;
         endcase
      end
   end

   // reset image of the loopback/led register follows the straps
   logic [7:0] loop_led_rst;
   always_comb
   begin
      loop_led_rst = 8'h00;
      loop_led_rst[`SGC_LL_LED_HI] = led_mode_sel_hi_i; // [RULE13]
      loop_led_rst[`SGC_LL_ERR_DROP] = error_drop_strap_i; // [RULE13]
      loop_led_rst[`SGC_LL_LOOP_HI] = `SGC_RST_LOOP_HI;
      loop_led_rst[`SGC_LL_LOOP_LO] = loop_position_strap_i; // [RULE13]
      loop_led_rst[`SGC_LL_LED_LO] = led_mode_sel_lo_i; // [RULE13]
   end

   // reset is synchronous, so straps are caught on the reset edges
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         storm_hi_q <= `SGC_RST_STORM_HI;
         storm_lo_q <= `SGC_RST_STORM_LO; // [RULE5]
         ftest1_q <= `SGC_RST_FTEST_1; // [RULE7]
         ftest2_q <= `SGC_RST_FTEST_2; // [RULE7]
         ftest3_q <= `SGC_RST_FTEST_3; // [RULE7]
         loop_led_q <= loop_led_rst; // [RULE13]
         pmap_lo_q <= `SGC_RST_PMAP_LO; // [RULE16]
         pmap_hi_q <= `SGC_RST_PMAP_HI; // [RULE16]
      end
      else if (ce_i)
      begin
         storm_hi_q <= storm_hi_d;
         storm_lo_q <= storm_lo_d;
         ftest1_q <= ftest1_d;
         ftest2_q <= ftest2_d;
         ftest3_q <= ftest3_d;
         loop_led_q <= loop_led_d;
         pmap_lo_q <= pmap_lo_d;
         pmap_hi_q <= pmap_hi_d;
      end
   end

   // storm limiter
   sgc_storm_if st_if ();

   assign st_if.limit = {storm_hi_q, storm_lo_q}; // [RULE1] [RULE2]
   assign st_if.byte_stb = storm_byte_i;
   assign st_if.speed_10 = port_speed_10_i;
   assign storm_drop_o = st_if.drop;

   sgc_storm #(
      .PERIOD_100_CYC(PERIOD_100_CYC),
      .PERIOD_10_CYC(PERIOD_10_CYC)
   ) u_storm (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .st(st_if.storm)
   );

   // static controls
   sgc_loop_pos_e loop_pos_q, loop_pos_d;
   logic [1:0] led_mode_q, led_mode_d;
   logic direct_q, direct_d;

   always_comb
   begin
      // low bit set overrides the high bit
      if (loop_led_q[`SGC_LL_LOOP_LO]) // [RULE10]
         loop_pos_d = SGC_LOOP_P1_OPTICAL;
      else if (loop_led_q[`SGC_LL_LOOP_HI])
         loop_pos_d = SGC_LOOP_P2_MAC;
      else
         loop_pos_d = SGC_LOOP_P2_COPPER;
      led_mode_d = {loop_led_q[`SGC_LL_LED_HI],
                    loop_led_q[`SGC_LL_LED_LO]}; // [RULE12]
      direct_d = loop_led_q[`SGC_LL_DIRECT]; // [RULE14]
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         loop_pos_q <= SGC_LOOP_P2_COPPER;
         led_mode_q <= 2'b00;
         direct_q <= 1'b0;
      end
      else if (ce_i)
      begin
         loop_pos_q <= loop_pos_d;
         led_mode_q <= led_mode_d;
         direct_q <= direct_d;
      end
   end

   assign loop_pos_o = loop_pos_q;
   assign led_mode_o = led_mode_q;
   assign direct_fwd_en_o = direct_q;

   // loopback frame verdict
   logic fwd_q, fwd_d;
   logic disc_q, disc_d;
   logic bad;

   // errored frames count as bad only while error drop is set
   assign bad = loop_frame_oam_i ||
                (loop_led_q[`SGC_LL_ERR_DROP] && loop_frame_err_i);

   always_comb
   begin
      fwd_d = 1'b0;
      disc_d = 1'b0;
      if (loop_mode_i && loop_frame_done_i)
      begin
         disc_d = bad; // [RULE8] [RULE9]
         fwd_d = !bad; // [RULE8] [RULE9]
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         fwd_q <= 1'b0;
         disc_q <= 1'b0;
      end
      else if (ce_i)
      begin
         fwd_q <= fwd_d;
         disc_q <= disc_d;
      end
   end

   assign loop_forward_o = fwd_q;
   assign loop_discard_o = disc_q;

   // priority lookup
   sgc_qpri_t qpri_q, qpri_d;
   logic qval_q, qval_d;
   logic [15:0] pmap;

   assign pmap = {pmap_hi_q, pmap_lo_q};

   always_comb
   begin
      qval_d = tag_valid_i;
      qpri_d = qpri_q;
      if (tag_valid_i)
         qpri_d = pmap[{tag_pri_i, 1'b0} +: 2]; // [RULE15]
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         qpri_q <= 2'b00;
         qval_q <= 1'b0;
      end
      else if (ce_i)
      begin
         qpri_q <= qpri_d;
         qval_q <= qval_d;
      end
   end

   assign queue_pri_o = qpri_q;
   assign queue_pri_valid_o = qval_q;

endmodule

//--- verification/sgc_bank_chk.sv
// port assertions for the switch global control bank
`timescale 1ns/100ps
module sgc_bank_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // loopback and priority
   input wire logic loop_mode_i,
   input wire logic loop_frame_done_i,
   input wire logic loop_frame_oam_i,
   input wire logic loop_frame_err_i,
   input wire logic loop_forward_o,
   input wire logic loop_discard_o,
   input wire logic tag_valid_i,
   input wire logic queue_pri_valid_o
);
   default clocking @(posedge clk_i); endclocking
   // a low enable freezes every flop, so no answer is due then
   default disable iff (!rst_n_i || !ce_i);
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_frame;
      loop_frame_done_i && loop_mode_i;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> pready_o)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
   a_err_with_ready: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   a_misalign_err: assert property
      (s_setup ##0 (paddr_i[1:0] != 2'h0) |=> pslverr_o)
      else $error("misaligned access not refused");
   a_unmapped_err: assert property
      (s_setup ##0 (paddr_i[7:2] > 6'h0d) |=> pslverr_o && prdata_o == 0)
      else $error("unmapped access not refused");
   a_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
      else $error("upper read bits set");
   a_oam_discard: assert property
      (s_frame ##0 loop_frame_oam_i |=> loop_discard_o && !loop_forward_o)
      else $error("oam frame kept");
   a_good_forward: assert property
      (s_frame ##0 !loop_frame_oam_i && !loop_frame_err_i
      |=> loop_forward_o && !loop_discard_o)
      else $error("good frame not looped");
   a_no_frame_quiet: assert property (!(loop_frame_done_i && loop_mode_i)
      |=> !loop_forward_o && !loop_discard_o) else $error("stray verdict");
   a_prio_valid: assert property
      (1'b1 |=> queue_pri_valid_o == $past(tag_valid_i))
      else $error("bad pri valid");
endmodule
bind sgc_bank sgc_bank_chk sgc_bank_chk_i (.clk_i, .rst_n_i, .ce_i, .psel_i,
   .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .loop_mode_i,
   .loop_frame_done_i, .loop_frame_oam_i, .loop_frame_err_i,
   .loop_forward_o, .loop_discard_o, .tag_valid_i, .queue_pri_valid_o);

//--- verification/tb.sv
// self-checking bench for the switch global control bank
`timescale 1ns/100ps
`include "sgc_params.svh"
module tb;
   import sgc_pkg::*;
   logic clk_i, rst_n_i, ce_i, psel_i, penable_i, pwrite_i, pready_o;
   logic pslverr_o, led_mode_sel_hi_i, led_mode_sel_lo_i, perr;
   logic error_drop_strap_i, loop_position_strap_i, loop_mode_i;
   logic loop_frame_done_i, loop_frame_oam_i, loop_frame_err_i;
   logic loop_forward_o, loop_discard_o, direct_fwd_en_o, tag_valid_i;
   logic queue_pri_valid_o;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rdat;
   logic [2:0] storm_byte_i, port_speed_10_i, storm_drop_o, tag_pri_i;
   logic [1:0] led_mode_o;
   sgc_loop_pos_e loop_pos_o;
   sgc_qpri_t queue_pri_o;
   int num_errors = 0;
   int compares = 0;
   // short periods keep the storm runs brief
   sgc_bank #(.PERIOD_100_CYC(200), .PERIOD_10_CYC(400)) sgc_bank_i (
      .clk_i, .rst_n_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .led_mode_sel_hi_i,
      .led_mode_sel_lo_i, .error_drop_strap_i, .loop_position_strap_i,
      .storm_byte_i, .port_speed_10_i, .storm_drop_o, .loop_mode_i,
      .loop_frame_done_i, .loop_frame_oam_i, .loop_frame_err_i,
      .loop_forward_o, .loop_discard_o, .loop_pos_o, .led_mode_o,
      .direct_fwd_en_o, .tag_valid_i, .tag_pri_i, .queue_pri_o,
      .queue_pri_valid_o);
   initial
   begin
      clk_i = 0;
      forever #12.5 clk_i = ~clk_i;
   end
   task tally_and_finish;
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task tmo;
      num_errors++;
      $display("wait limit used up");
      tally_and_finish;
   endtask
   task chk(input string n, input logic [31:0] got, input logic [31:0] x);
      compares++;
      if (got !== x)
         $display("[FAIL] %s expected %h seen %h", n, x, got);
      if (got !== x)
         num_errors++;
   endtask
   // request held until ready is sampled high at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1;
      n = 0;
      do
      begin
         @(posedge clk_i);
         if (++n > 50)
            tmo;
      end while (pready_o !== 1'b1);
      rdat = prdata_o;
      perr = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   task wr(input logic [5:0] i, input logic [7:0] d);
      apb(1, {i, 2'h0}, {24'h0, d});
   endtask
   task rd(input string n, input logic [5:0] i, input logic [7:0] x);
      apb(0, {i, 2'h0}, 0);
      chk(n, rdat, {24'h0, x});
   endtask
   task t_reset;
      rd("storm hi", `SGC_IDX_STORM_HI, 8'h00);
      rd("storm lo", `SGC_IDX_STORM_LO, 8'h63);
      rd("ftest1", `SGC_IDX_FTEST_1, 8'h00);
      rd("ftest2", `SGC_IDX_FTEST_2, 8'h24);
      rd("ftest3", `SGC_IDX_FTEST_3, 8'h35);
      rd("loop led", `SGC_IDX_LOOP_LED, 8'hac);
      rd("map lo", `SGC_IDX_PMAP_LO, 8'h50);
      rd("map hi", `SGC_IDX_PMAP_HI, 8'hfa);
      chk("strap pos", loop_pos_o, SGC_LOOP_P1_OPTICAL);
      chk("strap led", led_mode_o, 2'h2);
      apb(0, 8'h38, 32'h0);
      chk("unmapped err", perr, 1'b1);
      chk("unmapped data", rdat, 32'h0);
      apb(1, 8'h1d, 32'hff);
      chk("misaligned", perr, 1'b1);
      rd("dropped write", `SGC_IDX_STORM_LO, 8'h63);
      $display("reset test done");
   endtask
   task t_static;
      logic [1:0] b;
      sgc_loop_pos_e ep;
      for (int k = 0; k < 4; k++)
      begin
         b = k[1:0];
         ep = b[0] ? SGC_LOOP_P1_OPTICAL :
            (b[1] ? SGC_LOOP_P2_MAC : SGC_LOOP_P2_COPPER);
         wr(`SGC_IDX_LOOP_LED,
            {b[1], 3'h0, b[1], b[0], b[0], b[1]});
         repeat (3) @(posedge clk_i);
         chk("pos", loop_pos_o, ep);
         chk("led", led_mode_o, {b[1], b[0]});
         chk("direct", direct_fwd_en_o, b[1]);
      end
      $display("static test done");
   endtask
   task frame(input logic m, input logic o, input logic e);
      @(posedge clk_i);
      loop_mode_i <= m;
      loop_frame_done_i <= 1;
      loop_frame_oam_i <= o;
      loop_frame_err_i <= e;
      @(posedge clk_i);
      loop_frame_done_i <= 0;
      #1;
   endtask
   task t_loop;
      logic [2:0] b;
      for (int k = 0; k < 8; k++)
      begin
         b = k[2:0];
         if (b[1:0] == 2'h0)
            wr(`SGC_IDX_LOOP_LED, {2'h0, b[2], 5'h0});
         frame(1, b[1], b[0]);
         chk("discard", loop_discard_o,
             b[1] | b[0] & b[2]);
         chk("forward", loop_forward_o,
             !(b[1] | b[0] & b[2]));
      end
      frame(0, 1, 0);
      chk("no loop", {loop_forward_o, loop_discard_o}, 2'h0);
      $display("loopback test done");
   endtask
   task pri(input logic [2:0] p, input logic [1:0] x);
      @(posedge clk_i);
      tag_valid_i <= 1;
      tag_pri_i <= p;
      @(posedge clk_i);
      tag_valid_i <= 0;
      #1;
      chk("pri", {queue_pri_valid_o, queue_pri_o}, {1'b1, x});
   endtask
   task t_prio;
      for (int k = 0; k < 8; k++)
         pri(k[2:0], k[2:1]);
      wr(`SGC_IDX_PMAP_LO, 8'h1b);
      wr(`SGC_IDX_PMAP_HI, 8'he4);
      for (int k = 0; k < 8; k++)
         pri(k[2:0], k < 4 ? 2'(3 - k) : 2'(k - 4));
      $display("priority test done");
   endtask
   task wt(input int p, input logic v, output int n);
      n = 0;
      while (storm_drop_o[p] !== v)
      begin
         @(posedge clk_i);
         if (++n > 1000)
            tmo;
      end
   endtask
   // aligns on a period start, then times the low and high spans
   task meas(input int p, output int lo, output int per);
      int h;
      wt(p, 0, h);
      wt(p, 1, h);
      wt(p, 0, h);
      wt(p, 1, lo);
      wt(p, 0, h);
      per = lo + h;
   endtask
   task t_storm;
      int l1, l2, per, hits;
      @(posedge clk_i);
      port_speed_10_i <= 3'h4;
      storm_byte_i <= 3'h5;
      wr(`SGC_IDX_STORM_HI, 8'h00);
      wr(`SGC_IDX_STORM_LO, 8'h01);
      meas(0, l1, per);
      chk("period 100", per, 200);
      meas(2, l2, per);
      chk("period 10", per, 400);
      wr(`SGC_IDX_STORM_LO, 8'h02);
      meas(0, l2, per);
      chk("block size", l2 - l1, 64);
      chk("idle port", storm_drop_o[1], 1'b0);
      wr(`SGC_IDX_STORM_HI, 8'h01);
      wr(`SGC_IDX_STORM_LO, 8'h00);
      repeat (250) @(posedge clk_i);
      hits = 0;
      repeat (400) @(posedge clk_i) hits += storm_drop_o[0];
      chk("high bits", hits, 0);
      $display("storm test done");
   endtask
   // a tag seen while the enable is low must leave no answer
   task t_ce;
      @(posedge clk_i);
      ce_i <= 0;
      tag_valid_i <= 1;
      tag_pri_i <= 3'h7;
      @(posedge clk_i);
      tag_valid_i <= 0;
      #1;
      chk("frozen valid", queue_pri_valid_o, 1'b0);
      @(posedge clk_i);
      ce_i <= 1;
      $display("clock enable test done");
   endtask
   // reset again in mid-run with the opposite strap levels
   task t_rst2;
      @(posedge clk_i);
      rst_n_i <= 0;
      {led_mode_sel_hi_i, error_drop_strap_i} <= 2'h0;
      {led_mode_sel_lo_i, loop_position_strap_i} <= 2'h2;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1;
      rd("strap image", `SGC_IDX_LOOP_LED, 8'h0a);
      rd("storm lo again", `SGC_IDX_STORM_LO, 8'h63);
      chk("strap pos 2", loop_pos_o, SGC_LOOP_P2_MAC);
      chk("strap led 2", led_mode_o, 2'h1);
      $display("second reset test done");
   endtask
   initial
   begin
      {rst_n_i, psel_i, penable_i, pwrite_i, loop_mode_i} = 0;
      {loop_frame_done_i, loop_frame_oam_i, loop_frame_err_i} = 0;
      {tag_valid_i, tag_pri_i, paddr_i, pwdata_i} = 0;
      {storm_byte_i, port_speed_10_i, led_mode_sel_lo_i} = 0;
      {ce_i, led_mode_sel_hi_i, error_drop_strap_i} = 3'h7;
      loop_position_strap_i = 1;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1;
      t_reset;
      t_static;
      t_loop;
      t_prio;
      t_storm;
      t_ce;
      t_rst2;
      tally_and_finish;
   end
   initial
   begin
      repeat (100000) @(posedge clk_i);
      tmo;
   end
endmodule
